// [test/pmc_channel_props.sv]
`timescale 1ns/10ps
module pmc_channel_props
  import pmc_pkg::*;
(
  input wire logic clk_i, // Clock
  input wire logic rst_i, // Reset
  input wire logic wb_cyc_i, // Cycle
  input wire logic wb_stb_i, // Strobe
  input wire logic wb_we_i, // Write
  input wire logic [7:0] wb_adr_i, // Address
  input wire logic [31:0] wb_dat_i, // Write data
  input wire logic wb_ack_o, // Ack
  input wire logic fault_i, // Fault pin
  input wire logic mode_switch_i, // Mode switch
  input wire logic pwm_a_o, // Output A
  input wire logic pwm_b_o, // Output B
  input wire logic sync_o, // Alignment out
  input wire logic err_conv_trig_o, // Error converter trigger
  input wire logic gen_conv_start_o, // General converter start
  input wire logic chan_event_o, // Event pulse
  input wire logic fault_active_o // Fault flag
);
  default clocking cb @(posedge clk_i);
  endclocking
  logic clr_w;
  assign clr_w = wb_ack_o && wb_we_i && wb_adr_i == OFS_STATUS && wb_dat_i[STAT_FAULT];
  sequence s_req;
    wb_cyc_i && wb_stb_i && !wb_ack_o;
  endsequence
  sequence s_hold;
    fault_active_o && !clr_w;
  endsequence
  property p_ack_next;
    disable iff (rst_i) s_req |=> wb_ack_o;
  endproperty
  a_ack_next: assert property (p_ack_next) else $error("ack late");
  property p_ack_pulse;
    disable iff (rst_i) wb_ack_o |=> !wb_ack_o;
  endproperty
  a_ack_pulse: assert property (p_ack_pulse) else $error("ack too long");
  property p_rst_quiet;
    rst_i |=> !wb_ack_o && !pwm_a_o && !pwm_b_o && !fault_active_o;
  endproperty
  a_rst_quiet: assert property (p_rst_quiet) else $error("outputs active in reset");
  property p_fault_latch;
    disable iff (rst_i) $rose(fault_i) |-> ##[2:6] fault_active_o;
  endproperty
  a_fault_latch: assert property (p_fault_latch) else $error("fault not latched");
  property p_fault_hold;
    disable iff (rst_i) s_hold |=> fault_active_o;
  endproperty
  a_fault_hold: assert property (p_fault_hold) else $error("fault flag lost");
  property p_mode_event;
    disable iff (rst_i) mode_switch_i |-> ##[1:2] chan_event_o;
  endproperty
  a_mode_event: assert property (p_mode_event) else $error("no mode event");
  property p_gen_event;
    disable iff (rst_i) gen_conv_start_o |-> chan_event_o;
  endproperty
  a_gen_event: assert property (p_gen_event) else $error("start without event");
  property p_trig_pulse;
    disable iff (rst_i) err_conv_trig_o |=> !err_conv_trig_o;
  endproperty
  a_trig_pulse: assert property (p_trig_pulse) else $error("trigger too long");
  property p_sync_pulse;
    disable iff (rst_i) sync_o |=> !sync_o;
  endproperty
  a_sync_pulse: assert property (p_sync_pulse) else $error("alignment too long");
endmodule : pmc_channel_props
bind pmc_channel pmc_channel_props u_props (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i),
  .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_dat_i(wb_dat_i), .wb_ack_o(wb_ack_o),
  .fault_i(fault_i), .mode_switch_i(mode_switch_i), .pwm_a_o(pwm_a_o), .pwm_b_o(pwm_b_o), .sync_o(sync_o),
  .err_conv_trig_o(err_conv_trig_o), .gen_conv_start_o(gen_conv_start_o), .chan_event_o(chan_event_o),
  .fault_active_o(fault_active_o));

// [test/pmc_peer_model.sv]
`timescale 1ns/10ps
module pmc_peer_model (
  input wire logic clk_i, // Clock
  input wire logic run_i, // Emit alignment pulses
  input wire logic fault_req_i, // Raise fault
  output logic sync_o = 1'b0, // Alignment to channel
  output logic fault_o = 1'b0 // Fault line
);
  logic [2:0] tick_reg = 3'h0;
  always @(posedge clk_i) begin
    tick_reg <= run_i ? tick_reg + 3'h1 : 3'h0;
    sync_o <= run_i && tick_reg >= 3'h6;
    fault_o <= fault_req_i;
  end
endmodule : pmc_peer_model

// [test/testbench.sv]
`timescale 1ns/10ps
module testbench;
  import pmc_pkg::*;
  logic clk_i = 0, rst_i = 1, cyc = 0, stb = 0, we = 0, dv = 0, ms = 0, run = 0, fq = 0, a_prev = 0;
  logic [7:0] adr = 0;
  logic [3:0] sel = 4'hF, wsel = 4'hF;
  logic [FW-1:0] fna, fnb;
  logic [31:0] dat = 0, dat_o, r;
  logic [DW-1:0] duty = 0;
  logic ack, pa, pb, so, et, gs, ev, fa, sy, ft;
  logic [31:0] evt[4] = '{32'h23, 32'hA0, 32'hC0, 32'h117};
  int miscompares = 0, samples_checked = 0, seed = 32'hfe9e582d, gap = 0, wid = 0, cs, ce, cg, hi;
  logic [31:0] rq[$];
  int pq[$], wq[$];
  always #12.5 clk_i = ~clk_i;
  pmc_channel DUT (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr),
    .wb_sel_i(sel), .wb_dat_i(dat), .wb_dat_o(dat_o), .wb_ack_o(ack), .duty_i(duty), .duty_valid_i(dv),
    .sync_i(sy), .fault_i(ft), .mode_switch_i(ms), .pwm_a_o(pa), .pwm_b_o(pb), .fine_a_o(fna), .fine_b_o(fnb),
    .sync_o(so), .err_conv_trig_o(et), .gen_conv_start_o(gs), .chan_event_o(ev), .fault_active_o(fa));
  pmc_peer_model u_peer (.clk_i(clk_i), .run_i(run), .fault_req_i(fq), .sync_o(sy), .fault_o(ft));
  task automatic chk_word(input logic [31:0] g, input logic [31:0] e);
    samples_checked++;
    if (g !== e) begin
      miscompares++;
      $display("ERROR %0t got %h exp %h", $time, g, e);
    end
  endtask : chk_word
  task automatic chk_cnt(input int g, input int e);
    chk_word(32'(g), 32'(e));
  endtask : chk_cnt
  task automatic xfer(input logic [7:0] a, input logic w, input logic [31:0] d);
    @(posedge clk_i);
    cyc <= 1; stb <= 1; we <= w; adr <= a; dat <= d;
    sel <= wsel;
    do begin
      @(posedge clk_i);
    end while (ack !== 1'b1);
    cyc <= 0; stb <= 0;
  endtask : xfer
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    xfer(a, 1'b1, d);
  endtask : wr
  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    rq.push_back(e);
    xfer(a, 1'b0, 32'h0);
  endtask : rd
  task automatic wait_rise;
    logic p;
    p = pa;
    forever begin
      @(posedge clk_i);
      if (pa === 1'b1 && p === 1'b0) break;
      p = pa;
    end
    @(posedge clk_i);
  endtask : wait_rise
  task automatic count_win(input int n);
    cs = 0; ce = 0; cg = 0; hi = 0;
    repeat (n) begin
      @(posedge clk_i);
      if ($isunknown({so, et, gs, pa, pb})) miscompares++;
      cs += so; ce += et; cg += gs; hi += (pa | pb);
    end
  endtask : count_win
  task automatic final_report;
    // Notes never matched by an observed result count as mismatches
    miscompares += rq.size() + pq.size() + wq.size();
    $display("checks %0d mismatches %0d", samples_checked, miscompares);
    if (miscompares == 0 && samples_checked > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask : final_report
  // Read data and pulse timing are checked against notes queued by the driver
  always @(posedge clk_i) begin
    if (ack === 1'b1 && !we && rq.size() > 0) chk_word(dat_o, rq.pop_front());
    if (pa === 1'b1 && a_prev === 1'b0) begin
      if (pq.size() > 0) chk_cnt(gap, pq.pop_front());
      gap = 0;
    end
    if (pa === 1'b0 && a_prev === 1'b1 && wq.size() > 0) chk_cnt(wid, wq.pop_front());
    wid = (pa === 1'b1) ? wid + 1 : 0;
    gap++;
    a_prev = pa;
  end
  initial begin
    #125000;
    miscompares++;
    final_report;
  end
  initial begin
    repeat (6) @(posedge clk_i);
    rst_i <= 0;
    rd(OFS_CTRL, 32'h0);
    rd(OFS_PERIOD, 32'hFF);
    rd(8'hFC, 32'h0);
    for (int i = 0; i < 3; i++) begin
      r = $random(seed) & 32'h3FFF;
      wr(OFS_SAMPLE + 8'(4 * i), r);
      rd(OFS_SAMPLE + 8'(4 * i), r);
    end
    wsel = 4'h2;
    wr(OFS_SLAVE, 32'hFFFF_3F00);
    wsel = 4'hF;
    rd(OFS_SLAVE, (r & 32'h0000_00FF) | 32'h0000_3F00);
    wr(OFS_SAMPLE, 32'h5);
    wr(OFS_PHASE, 32'h7);
    wr(OFS_SLAVE, 32'hF);
    wr(OFS_PERIOD, 32'h13);
    wr(OFS_IDIV, 32'h1);
    for (int i = 0; i < 4; i++) wr(OFS_EV1 + 8'(4 * i), evt[i]);
    wr(OFS_CTRL, 32'h1);
    repeat (3) wait_rise;
    chk_word({24'h0, fna, fnb}, 32'h0000_0037);
    wq.push_back(8);
    pq.push_back(20);
    pq.push_back(30);
    wr(OFS_PERIOD, 32'h1D);
    repeat (2) wait_rise;
    count_win(120);
    chk_cnt(cs, 4);
    chk_cnt(ce, 4);
    chk_cnt(cg, 2);
    wr(OFS_ADJ_A, 32'h20);
    wait_rise;
    wq.push_back(10);
    // Let this pulse fall before its fall point moves earlier
    repeat (12) @(posedge clk_i);
    wr(OFS_ADJ_A, 32'hFFE0);
    wait_rise;
    wq.push_back(6);
    wait_rise;
    wr(OFS_CTRL, 32'h5);
    run <= 1;
    repeat (40) @(posedge clk_i);
    count_win(60);
    chk_cnt(cs + ce, 0);
    run <= 0;
    wr(OFS_CTRL, 32'h8);
    repeat (3) @(posedge clk_i);
    chk_word({30'h0, pa, pb}, 32'h3);
    wr(OFS_CTRL, 32'h2);
    duty <= 24'h40_0000;
    dv <= 1;
    @(posedge clk_i);
    dv <= 0;
    rd(OFS_ONTIME, 32'h0000_00E8);
    wr(OFS_CTRL, 32'h11);
    duty <= DW'($random(seed));
    dv <= 1;
    ms <= 1;
    @(posedge clk_i);
    dv <= 0;
    ms <= 0;
    fq <= 1;
    repeat (8) @(posedge clk_i);
    fq <= 0;
    chk_word({31'h0, fa}, 32'h1);
    count_win(40);
    chk_cnt(hi, 0);
    wr(OFS_STATUS, 32'h4000);
    @(posedge clk_i);
    chk_word({31'h0, fa}, 32'h0);
    rst_i <= 1;
    repeat (2) @(posedge clk_i);
    rst_i <= 0;
    rd(OFS_PERIOD, 32'hFF);
    repeat (3) @(posedge clk_i);
    final_report;
  end
endmodule : testbench

// [verilog/pmc_channel.sv]
// The register addresses and register access over Wishbone were left to the implementer.
`timescale 1ns/10ps
module pmc_channel
  import pmc_pkg::*;
(
  input wire logic clk_i, // 40 MHz clock
  input wire logic rst_i, // Synchronous reset, high
  input wire logic wb_cyc_i, // Wishbone cycle
  input wire logic wb_stb_i, // Wishbone strobe
  input wire logic wb_we_i, // Wishbone write
  input wire logic [7:0] wb_adr_i, // Byte address
  input wire logic [3:0] wb_sel_i, // Byte enables
  input wire logic [31:0] wb_dat_i, // Write data
  output logic [31:0] wb_dat_o, // Read data
  output logic wb_ack_o, // Acknowledge
  input wire logic [DW-1:0] duty_i, // Q23 duty from filter
  input wire logic duty_valid_i, // Duty strobe
  input wire logic sync_i, // Alignment input pin
  input wire logic fault_i, // Fault input pin
  input wire logic mode_switch_i, // Mode switch event
  output logic pwm_a_o, // Output A
  output logic pwm_b_o, // Output B
  output logic [FW-1:0] fine_a_o, // A fine edge delay
  output logic [FW-1:0] fine_b_o, // B fine edge delay
  output logic sync_o, // Alignment output pulse
  output logic err_conv_trig_o, // Error converter trigger
  output logic gen_conv_start_o, // General converter start
  output logic chan_event_o, // Interrupt event pulse
  output logic fault_active_o // Fault latched
);
  logic [5:0] ctrl_reg;
  logic [CW-1:0] period_shadow_reg, period_reg, cnt_reg;
  logic [CW-1:0] sample_reg, phase_reg, slave_reg;
  logic [EW-1:0] ev1_reg, ev2_reg, ev3_reg, ev4_reg;
  logic [AW-1:0] adj_a_reg, adj_b_reg;
  logic [7:0] idiv_reg, icnt_reg, dead_reg, dead_a_reg, dead_b_reg;
  logic [DW-1:0] duty_reg;
  logic fault_reg, ack_reg;
  logic [2:0] sync_sh_reg, fault_sh_reg;
  logic sync_lvl_reg, sync_prev_reg, fault_lvl_reg, fault_prev_reg;
  logic wr, rd_hit, wrap, sync_edge, fault_edge, en, run;
  logic [31:0] rd_data, wdata;
  logic [EW-1:0] on_time, fall_a, fall_b;
  logic a_raw, b_raw, a_raw_d_reg, b_raw_d_reg, a_gate, b_gate;
  logic [DW-2+EW:0] prod;

  function automatic logic [31:0] merge(input logic [31:0] o, input logic [31:0] n,
                                        input logic [3:0] s);
    logic [31:0] r;
    r = o;
    for (int i = 0; i < 4; i++) begin
      if (s[i]) begin
        r[8*i +: 8] = n[8*i +: 8];
      end
    end
    return r;
  endfunction : merge

  function automatic logic [EW-1:0] add_adj(input logic [EW-1:0] e, input logic [AW-1:0] a);
    logic signed [EW+1:0] s;
    s = $signed({2'b00, e}) + $signed({{(EW+2-AW){a[AW-1]}}, a});
    if (s < 0) begin
      return '0;
    end else if (s[EW]) begin
      return '1;
    end
    return s[EW-1:0];
  endfunction : add_adj

  // Bus: registered ack, write lands at the ack edge
  assign wr = wb_cyc_i && wb_stb_i && wb_we_i && ack_reg;
  assign wb_ack_o = ack_reg;

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ack_reg <= 1'b0;
    end else begin
      ack_reg <= wb_cyc_i && wb_stb_i && !ack_reg;
    end
  end

  always_comb begin
    rd_hit = 1'b1;
    rd_data = '0;
    case (wb_adr_i)
      OFS_CTRL: rd_data[5:0] = ctrl_reg;
      OFS_PERIOD: rd_data[CW-1:0] = period_shadow_reg;
      OFS_EV1: rd_data[EW-1:0] = ev1_reg;
      OFS_EV2: rd_data[EW-1:0] = ev2_reg;
      OFS_EV3: rd_data[EW-1:0] = ev3_reg;
      OFS_EV4: rd_data[EW-1:0] = ev4_reg;
      OFS_ADJ_A: rd_data[AW-1:0] = adj_a_reg;
      OFS_ADJ_B: rd_data[AW-1:0] = adj_b_reg;
      OFS_SAMPLE: rd_data[CW-1:0] = sample_reg;
      OFS_PHASE: rd_data[CW-1:0] = phase_reg;
      OFS_SLAVE: rd_data[CW-1:0] = slave_reg;
      OFS_DEAD: rd_data[7:0] = dead_reg;
      OFS_IDIV: rd_data[7:0] = idiv_reg;
      OFS_STATUS: rd_data = {16'h0000, 1'b0, fault_reg, cnt_reg};
      OFS_ONTIME: rd_data[EW-1:0] = on_time;
      default: rd_hit = 1'b0;
    endcase
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      wb_dat_o <= 32'h0000_0000;
    end else if (wb_cyc_i && wb_stb_i && !ack_reg) begin
      wb_dat_o <= rd_hit ? rd_data : 32'h0000_0000;
    end
  end

  // Byte lanes merged over the addressed register's present value
  assign wdata = merge(rd_data, wb_dat_i, wb_sel_i);

  // Control bits
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ctrl_reg <= RST_CTRL;
    end else if (wr && wb_adr_i == OFS_CTRL) begin
      ctrl_reg <= wdata[5:0];
    end
  end

  // Period shadow, taken over by the time base at wrap
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      period_shadow_reg <= RST_PERIOD;
    end else if (wr && wb_adr_i == OFS_PERIOD) begin
      period_shadow_reg <= wdata[CW-1:0];
    end
  end

  // Edge events
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ev1_reg <= RST_EV;
      ev2_reg <= RST_EV;
      ev3_reg <= RST_EV;
      ev4_reg <= RST_EV;
    end else if (wr) begin
      case (wb_adr_i)
        OFS_EV1: ev1_reg <= wdata[EW-1:0];
        OFS_EV2: ev2_reg <= wdata[EW-1:0];
        OFS_EV3: ev3_reg <= wdata[EW-1:0];
        OFS_EV4: ev4_reg <= wdata[EW-1:0];
        default: ;
      endcase
    end
  end

  // Cycle adjusts
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      adj_a_reg <= RST_ADJ;
      adj_b_reg <= RST_ADJ;
    end else if (wr) begin
      case (wb_adr_i)
        OFS_ADJ_A: adj_a_reg <= wdata[AW-1:0];
        OFS_ADJ_B: adj_b_reg <= wdata[AW-1:0];
        default: ;
      endcase
    end
  end

  // Trigger points and slave load value
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      sample_reg <= RST_CNT;
      phase_reg <= RST_CNT;
      slave_reg <= RST_CNT;
    end else if (wr) begin
      case (wb_adr_i)
        OFS_SAMPLE: sample_reg <= wdata[CW-1:0];
        OFS_PHASE: phase_reg <= wdata[CW-1:0];
        OFS_SLAVE: slave_reg <= wdata[CW-1:0];
        default: ;
      endcase
    end
  end

  // Dead time and event divider
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      dead_reg <= RST_DEAD;
      idiv_reg <= RST_IDIV;
    end else if (wr) begin
      case (wb_adr_i)
        OFS_DEAD: dead_reg <= wdata[7:0];
        OFS_IDIV: idiv_reg <= wdata[7:0];
        default: ;
      endcase
    end
  end

  // Pin inputs: three flops, a change counts when stages two and three agree
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      sync_sh_reg <= 3'b000;
      fault_sh_reg <= 3'b000;
      sync_lvl_reg <= 1'b0;
      fault_lvl_reg <= 1'b0;
      sync_prev_reg <= 1'b0;
      fault_prev_reg <= 1'b0;
    end else begin
      sync_sh_reg <= {sync_sh_reg[1:0], sync_i};
      fault_sh_reg <= {fault_sh_reg[1:0], fault_i};
      if (sync_sh_reg[1] == sync_sh_reg[2]) begin
        sync_lvl_reg <= sync_sh_reg[2];
      end
      if (fault_sh_reg[1] == fault_sh_reg[2]) begin
        fault_lvl_reg <= fault_sh_reg[2];
      end
      sync_prev_reg <= sync_lvl_reg;
      fault_prev_reg <= fault_lvl_reg;
    end
  end

  assign sync_edge = sync_lvl_reg && !sync_prev_reg;
  assign fault_edge = fault_lvl_reg && !fault_prev_reg;
  assign en = ctrl_reg[CTRL_EN];
  assign run = en && !(fault_reg && ctrl_reg[CTRL_FAULT_EN]);
  assign wrap = en && (cnt_reg >= period_reg);

  // Time base
  always_ff @(posedge clk_i) begin
    if (rst_i || !en) begin
      cnt_reg <= RST_CNT;
      period_reg <= period_shadow_reg;
    end else if (ctrl_reg[CTRL_SYNC_EN] && sync_edge) begin
      cnt_reg <= slave_reg;
    end else if (wrap) begin
      cnt_reg <= RST_CNT;
      period_reg <= period_shadow_reg;
    end else begin
      cnt_reg <= cnt_reg + 14'h0001;
    end
  end

  // Closed loop on-time: duty fraction times period in fine steps
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      duty_reg <= '0;
    end else if (duty_valid_i) begin
      duty_reg <= duty_i;
    end
  end

  assign prod = duty_reg[DW-2:0] * {period_reg, 4'h0};
  always_comb begin
    if (!ctrl_reg[CTRL_CLOSED]) begin
      on_time = ev2_reg;
    end else if (duty_reg[DW-1]) begin
      on_time = '0;
    end else begin
      on_time = prod[DW-2+EW:DW-1];
    end
  end

  assign fall_a = add_adj(on_time, adj_a_reg);
  assign fall_b = add_adj(ev4_reg, adj_b_reg);

  pmc_edge u_edge_a (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .en_i(run),
    .cnt_i(cnt_reg),
    .rise_i(ev1_reg),
    .fall_i(fall_a),
    .lvl_o(a_raw),
    .fine_o(fine_a_o)
  );

  pmc_edge u_edge_b (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .en_i(run),
    .cnt_i(cnt_reg),
    .rise_i(ev3_reg),
    .fall_i(fall_b),
    .lvl_o(b_raw),
    .fine_o(fine_b_o)
  );

  // Dead time: each output waits after the other one falls
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      a_raw_d_reg <= 1'b0;
      b_raw_d_reg <= 1'b0;
      dead_a_reg <= 8'h00;
      dead_b_reg <= 8'h00;
    end else begin
      a_raw_d_reg <= a_raw;
      b_raw_d_reg <= b_raw;
      if (b_raw_d_reg && !b_raw) begin
        dead_a_reg <= dead_reg;
      end else if (dead_a_reg != 8'h00) begin
        dead_a_reg <= dead_a_reg - 8'h01;
      end
      if (a_raw_d_reg && !a_raw) begin
        dead_b_reg <= dead_reg;
      end else if (dead_b_reg != 8'h00) begin
        dead_b_reg <= dead_b_reg - 8'h01;
      end
    end
  end

  assign a_gate = a_raw && (dead_a_reg == 8'h00) && !(dead_reg != 8'h00 && b_raw);
  assign b_gate = b_raw && (dead_b_reg == 8'h00) && !(dead_reg != 8'h00 && a_raw);

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      pwm_a_o <= 1'b0;
      pwm_b_o <= 1'b0;
    end else begin
      pwm_a_o <= a_gate ^ ctrl_reg[CTRL_POL_LOW];
      pwm_b_o <= b_gate ^ ctrl_reg[CTRL_POL_LOW];
    end
  end

  // Fault flag: set wins over a write-one clear
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      fault_reg <= 1'b0;
    end else if (fault_edge) begin
      fault_reg <= 1'b1;
    end else if (wr && wb_adr_i == OFS_STATUS && wb_sel_i[1] && wb_dat_i[STAT_FAULT]) begin
      fault_reg <= 1'b0;
    end
  end

  // Event outputs
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      icnt_reg <= 8'h00;
      sync_o <= 1'b0;
      err_conv_trig_o <= 1'b0;
      gen_conv_start_o <= 1'b0;
      chan_event_o <= 1'b0;
    end else begin
      sync_o <= en && (cnt_reg == phase_reg);
      err_conv_trig_o <= en && (cnt_reg == sample_reg);
      gen_conv_start_o <= 1'b0;
      chan_event_o <= fault_edge || mode_switch_i;
      if (wrap) begin
        if (icnt_reg >= idiv_reg) begin
          icnt_reg <= 8'h00;
          gen_conv_start_o <= 1'b1;
          chan_event_o <= 1'b1;
        end else begin
          icnt_reg <= icnt_reg + 8'h01;
        end
      end
    end
  end

  assign fault_active_o = fault_reg;
endmodule : pmc_channel

// [verilog/pmc_edge.sv]
`timescale 1ns/10ps
module pmc_edge
  import pmc_pkg::*;
(
  input wire logic clk_i, // System clock
  input wire logic rst_i, // Synchronous reset
  input wire logic en_i, // Channel running
  input wire logic [CW-1:0] cnt_i, // Time base
  input wire logic [EW-1:0] rise_i, // Rising edge, fine units
  input wire logic [EW-1:0] fall_i, // Falling edge, fine units
  output logic lvl_o, // Raw output level
  output logic [FW-1:0] fine_o // Fine delay of last edge
);
  always_ff @(posedge clk_i) begin
    if (rst_i || !en_i) begin
      lvl_o <= 1'b0;
      fine_o <= '0;
    end else if (cnt_i == fall_i[EW-1:FW]) begin
      lvl_o <= 1'b0;
      fine_o <= fall_i[FW-1:0];
    end else if (cnt_i == rise_i[EW-1:FW]) begin
      lvl_o <= 1'b1;
      fine_o <= rise_i[FW-1:0];
    end
  end
endmodule : pmc_edge

// [verilog/pmc_pkg.sv]
package pmc_pkg;
  localparam int CW = 14;
  localparam int FW = 4;
  localparam int EW = CW + FW;
  localparam int DW = 24;
  localparam int AW = 16;
  localparam logic [7:0] OFS_CTRL = 8'h00;
  localparam logic [7:0] OFS_PERIOD = 8'h04;
  localparam logic [7:0] OFS_EV1 = 8'h08;
  localparam logic [7:0] OFS_EV2 = 8'h0C;
  localparam logic [7:0] OFS_EV3 = 8'h10;
  localparam logic [7:0] OFS_EV4 = 8'h14;
  localparam logic [7:0] OFS_ADJ_A = 8'h18;
  localparam logic [7:0] OFS_ADJ_B = 8'h1C;
  localparam logic [7:0] OFS_SAMPLE = 8'h20;
  localparam logic [7:0] OFS_PHASE = 8'h24;
  localparam logic [7:0] OFS_SLAVE = 8'h28;
  localparam logic [7:0] OFS_DEAD = 8'h2C;
  localparam logic [7:0] OFS_IDIV = 8'h30;
  localparam logic [7:0] OFS_STATUS = 8'h34;
  localparam logic [7:0] OFS_ONTIME = 8'h38;
  localparam int CTRL_EN = 0;
  localparam int CTRL_CLOSED = 1;
  localparam int CTRL_SYNC_EN = 2;
  localparam int CTRL_POL_LOW = 3;
  localparam int CTRL_FAULT_EN = 4;
  localparam int STAT_FAULT = 14;
  localparam logic [5:0] RST_CTRL = 6'h00;
  localparam logic [CW-1:0] RST_PERIOD = 14'h00FF;
  localparam logic [EW-1:0] RST_EV = 18'h0_0000;
  localparam logic [AW-1:0] RST_ADJ = 16'h0000;
  localparam logic [CW-1:0] RST_CNT = 14'h0000;
  localparam logic [7:0] RST_IDIV = 8'h00;
  localparam logic [7:0] RST_DEAD = 8'h00;
endpackage : pmc_pkg
